/* pkg/rca_cfg.svh */
`ifndef RCA_CFG_SVH
`define RCA_CFG_SVH
// ****************************************
// Pin mapping and scheme codes
// ****************************************
`define RCA_NUM_LINES 4
`define RCA_LINE_ONE 0
`define RCA_LINE_TWO 1
`define RCA_LINE_THREE 2
`define RCA_LINE_FOUR 3
`define RCA_SCHEME_W 3
`define RCA_SCH_TRAFFIC 3'h1
`define RCA_SCH_LAN_MASTER 3'h2
`define RCA_SCH_RADIO_MASTER 3'h3
`define RCA_SCH_TWO_WIRE 3'h4
`define RCA_SCH_ALTERNATE 3'h5
`define RCA_SCHEME_RESET 3'h1
// Fair-share slot count for traffic arbitration
`define RCA_SHARE_SLOTS 4'h2
`endif

/* pkg/rca_pkg.sv */
package rca_pkg;
  typedef enum logic [4:0] {
    RCA_SCH_TA = 5'b00001,
    RCA_SCH_LM = 5'b00010,
    RCA_SCH_RM = 5'b00100,
    RCA_SCH_TW = 5'b01000,
    RCA_SCH_AM = 5'b10000
  } rca_scheme_t;
endpackage : rca_pkg

/* design/rca_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module rca_sync #(
  parameter int WIDTH = 4
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] stage_one;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      stage_one <= '0;
      o_sync <= '0;
    end else begin
      stage_one <= i_async;
      o_sync <= stage_one;
    end
  end
endmodule : rca_sync
`default_nettype wire

/* design/rca_arbiter.sv */
// How it works
// - When enabled, four pins serve the LAN link; disabled leaves all idle.
// - Five schemes chosen by host; traffic arbitration after reset.
// - LAN-master: line one high from LAN suspends all radio activity.
// - Radio-master: we drive line two high whenever radio operates.
// - Two-wire: host picks which side is master; line one heeded if LAN master, line two driven if radio master.
// - Alternating: line one strobe hands medium between LAN and radio.
// - Traffic arbitration: grant one, ask two, status three, spare four.
// - Both busy: share slots by priority; one idle: other gets all.
`include "rca_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module rca_arbiter (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_coex_enable,
  input wire logic [2:0] i_scheme_sel,
  input wire logic i_scheme_load,
  input wire logic i_host_radio_master,
  input wire logic i_slot_boundary,
  input wire logic i_radio_request,
  input wire logic i_radio_priority,
  input wire logic [`RCA_NUM_LINES-1:0] i_coex_line,
  output logic [`RCA_NUM_LINES-1:0] o_coex_line,
  output logic [`RCA_NUM_LINES-1:0] o_coex_line_oe_n,
  output logic o_radio_allowed,
  output logic [2:0] o_scheme
);
  // ****************************************
  // Pin sampling
  // ****************************************
  logic [`RCA_NUM_LINES-1:0] line_sync;
  rca_sync #(.WIDTH(`RCA_NUM_LINES)) u_sync (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_async(i_coex_line),
    .o_sync(line_sync)
  );

  // ****************************************
  // Scheme selection
  // ****************************************
  rca_pkg::rca_scheme_t scheme;
  rca_pkg::rca_scheme_t next_scheme;
  logic [2:0] pending;
  logic pending_valid;
  logic sel_valid;
  assign sel_valid = (pending >= `RCA_SCH_TRAFFIC) &&
                     (pending <= `RCA_SCH_ALTERNATE);
  // Decoding of a pending code into one-hot
  always_comb begin
    next_scheme = scheme;
    if (pending_valid && i_slot_boundary && sel_valid) begin
      case (pending)
        `RCA_SCH_TRAFFIC: next_scheme = rca_pkg::RCA_SCH_TA;
        `RCA_SCH_LAN_MASTER: next_scheme = rca_pkg::RCA_SCH_LM;
        `RCA_SCH_RADIO_MASTER: next_scheme = rca_pkg::RCA_SCH_RM;
        `RCA_SCH_TWO_WIRE: next_scheme = rca_pkg::RCA_SCH_TW;
        default: next_scheme = rca_pkg::RCA_SCH_AM;
      endcase
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      scheme <= rca_pkg::RCA_SCH_TA;
      pending <= `RCA_SCHEME_RESET;
      pending_valid <= 1'b0;
    end else begin
      scheme <= next_scheme;
      // A late load still lands at the next boundary
      if (i_scheme_load) begin
        pending <= i_scheme_sel;
        pending_valid <= 1'b1;
      end else if (i_slot_boundary) begin
        pending_valid <= 1'b0;
      end
    end
  end

  wire is_ta = i_coex_enable && (scheme == rca_pkg::RCA_SCH_TA);
  wire is_lm = i_coex_enable && (scheme == rca_pkg::RCA_SCH_LM);
  wire is_rm = i_coex_enable && (scheme == rca_pkg::RCA_SCH_RM);
  wire is_tw = i_coex_enable && (scheme == rca_pkg::RCA_SCH_TW);
  wire is_am = i_coex_enable && (scheme == rca_pkg::RCA_SCH_AM);

  // ****************************************
  // Per-scheme line meaning
  // ****************************************
  // Sampled inputs are gated, so idle lines have no effect
  wire inbound_radio_block = (is_lm || (is_tw && !i_host_radio_master)) &&
                             line_sync[`RCA_LINE_ONE];
  wire medium_release_strobe = is_am && line_sync[`RCA_LINE_ONE];
  wire lan_status = is_ta && line_sync[`RCA_LINE_THREE];
  wire lan_spare = is_ta && line_sync[`RCA_LINE_FOUR];

  // ****************************************
  // Alternating medium share
  // ****************************************
  logic strobe_prev;
  logic radio_phase;
  wire strobe_rise = medium_release_strobe && !strobe_prev;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      strobe_prev <= 1'b0;
      radio_phase <= 1'b0;
    end else begin
      strobe_prev <= medium_release_strobe;
      if (!is_am) begin
        radio_phase <= 1'b0;
      end else if (strobe_rise) begin
        radio_phase <= !radio_phase;
      end
    end
  end

  // ****************************************
  // Traffic arbitration
  // ****************************************
  // LAN activity is signalled on the status line
  logic [3:0] share_cnt;
  logic radio_turn;
  wire both_busy = i_radio_request && lan_status;
  wire ta_grant = !lan_status ? 1'b1 :
                  !i_radio_request ? 1'b0 :
                  (i_radio_priority && !lan_spare) ? 1'b1 :
                  radio_turn;
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      share_cnt <= 4'h0;
      radio_turn <= 1'b1;
    end else if (both_busy && i_slot_boundary) begin
      // Fixed slot quota; simple time division, not weighted
      if (share_cnt == `RCA_SHARE_SLOTS - 4'h1) begin
        share_cnt <= 4'h0;
        radio_turn <= !radio_turn;
      end else begin
        share_cnt <= share_cnt + 4'h1;
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  wire next_allowed = is_ta ? ta_grant :
                      (is_lm || is_tw) ? !inbound_radio_block :
                      is_am ? radio_phase : 1'b1;
  wire drive_two = is_ta || is_rm || (is_tw && i_host_radio_master);
  wire [`RCA_NUM_LINES-1:0] next_oe_n;
  wire [`RCA_NUM_LINES-1:0] next_line;
  // Grant on one, ask on two; others listened to or unused
  assign next_oe_n = {2'b11, !drive_two, !is_ta};
  assign next_line = {2'b00, drive_two && i_radio_request,
                      is_ta && ta_grant && i_radio_request};

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      o_coex_line <= '0;
      o_coex_line_oe_n <= '1;
      o_radio_allowed <= 1'b1;
      o_scheme <= `RCA_SCHEME_RESET;
    end else begin
      o_coex_line <= next_line;
      o_coex_line_oe_n <= next_oe_n;
      o_radio_allowed <= next_allowed;
      o_scheme <= (scheme == rca_pkg::RCA_SCH_TA) ? `RCA_SCH_TRAFFIC :
                  (scheme == rca_pkg::RCA_SCH_LM) ? `RCA_SCH_LAN_MASTER :
                  (scheme == rca_pkg::RCA_SCH_RM) ? `RCA_SCH_RADIO_MASTER :
                  (scheme == rca_pkg::RCA_SCH_TW) ? `RCA_SCH_TWO_WIRE :
                  `RCA_SCH_ALTERNATE;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_block_seen;
    is_lm && line_sync[`RCA_LINE_ONE];
  endsequence
  a_lan_block_halts: assert property (@(posedge i_clk) disable iff (i_srst)
    s_block_seen |=> !o_radio_allowed)
    else $error("radio allowed while LAN blocks");
  a_reset_scheme: assert property (@(posedge i_clk)
    i_srst |=> o_scheme == 3'h1)
    else $error("scheme not traffic after reset");
  a_radio_block_out: assert property (@(posedge i_clk) disable iff (i_srst)
    is_rm && i_radio_request |=> o_coex_line[1] && !o_coex_line_oe_n[1])
    else $error("outbound block not driven");
  a_two_wire_lines: assert property (@(posedge i_clk) disable iff (i_srst)
    is_tw && i_host_radio_master |=> !o_coex_line_oe_n[1])
    else $error("two-wire line two not driven");
  a_alt_no_drive: assert property (@(posedge i_clk) disable iff (i_srst)
    is_am |=> o_coex_line_oe_n == 4'hf)
    else $error("alternating scheme drives a line");
  a_ta_pinmap: assert property (@(posedge i_clk) disable iff (i_srst)
    is_ta |=> o_coex_line_oe_n == 4'hc)
    else $error("traffic pin map wrong");
  a_idle_lan_full: assert property (@(posedge i_clk) disable iff (i_srst)
    is_ta && !line_sync[2] |=> o_radio_allowed)
    else $error("radio denied with LAN idle");
  a_switch_on_slot: assert property (@(posedge i_clk) disable iff (i_srst)
    !i_slot_boundary |=> $stable(scheme))
    else $error("scheme changed mid slot");
  a_disabled_idle: assert property (@(posedge i_clk) disable iff (i_srst)
    !i_coex_enable ##1 !i_coex_enable |=> o_coex_line_oe_n == 4'hf)
    else $error("line driven while disabled");
endmodule : rca_arbiter
`default_nettype wire

/* tb/rca_lan_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rca_lan_model (
  input wire logic i_clk,
  input wire logic [2:0] i_scheme,
  input wire logic i_lan_tx,
  input wire logic i_lan_prio,
  input wire logic i_strobe,
  input wire logic [3:0] i_dev_line,
  input wire logic [3:0] i_dev_oe_n,
  output logic [3:0] o_pin,
  output logic o_lan_may_run
);
  logic wander;
  logic [3:0] drv;
  logic [3:0] val;
  // Idle pins wander so a stale level is never mistaken for data
  // Single driver; settles to a known level after the first edge
  always_ff @(posedge i_clk) wander <= (wander === 1'b1) ? 1'b0 : 1'b1;
  always_comb begin
    drv = 4'h0;
    val = 4'h0;
    case (i_scheme)
      3'h1: begin
        drv = 4'hc;
        val = {i_lan_prio, i_lan_tx, 2'h0};
      end
      3'h2, 3'h4: begin
        drv = 4'h1;
        val = {3'h0, i_lan_tx};
      end
      3'h5: begin
        drv = 4'h1;
        val = {3'h0, i_strobe};
      end
      default: drv = 4'h0;
    endcase
  end
  assign o_pin = (~i_dev_oe_n & i_dev_line) | (i_dev_oe_n & drv & val)
    | (i_dev_oe_n & ~drv & {4{wander}});
  assign o_lan_may_run = !((i_scheme == 3'h3 || i_scheme == 3'h4)
    && o_pin[1]);
endmodule : rca_lan_model
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic i_clk = 1'b0;
  logic i_srst = 1'b1;
  logic en = 1'b1;
  logic [2:0] sel = 3'h1;
  logic load = 1'b0;
  logic hrm = 1'b0;
  logic slot = 1'b0;
  logic req = 1'b0;
  logic prio = 1'b0;
  logic tx = 1'b0;
  logic lp = 1'b0;
  logic strobe = 1'b0;
  logic [3:0] pin, line, oe_n;
  logic allowed, lan_ok;
  logic [2:0] scheme;
  logic [1:0] g;
  logic [3:0] corner [4] = '{4'hf, 4'hd, 4'h8, 4'h0};
  int n_fail = 0;
  int checks = 0;
  int seed = 74;
  int i;
  rca_arbiter DUT (.i_clk(i_clk), .i_srst(i_srst), .i_coex_enable(en),
    .i_scheme_sel(sel), .i_scheme_load(load), .i_host_radio_master(hrm),
    .i_slot_boundary(slot), .i_radio_request(req), .i_radio_priority(prio),
    .i_coex_line(pin), .o_coex_line(line), .o_coex_line_oe_n(oe_n),
    .o_radio_allowed(allowed), .o_scheme(scheme));
  rca_lan_model lan (.i_clk(i_clk), .i_scheme(sel), .i_lan_tx(tx),
    .i_lan_prio(lp), .i_strobe(strobe), .i_dev_line(line),
    .i_dev_oe_n(oe_n), .o_pin(pin), .o_lan_may_run(lan_ok));
  initial forever #5 i_clk = ~i_clk;
  // ****************************************
  // Helpers
  // ****************************************
  task automatic stop_test;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : cyc
  task automatic use_scheme(input logic [2:0] code, input logic [2:0] e);
    @(posedge i_clk);
    sel <= code;
    load <= 1'b1;
    @(posedge i_clk);
    load <= 1'b0;
    slot <= 1'b1;
    @(posedge i_clk);
    slot <= 1'b0;
    cyc(3);
    chk({5'h0, scheme}, {5'h0, e});
  endtask : use_scheme
  // No slot boundary in this test, so a shared medium stays on radio's turn
  function automatic logic [1:0] exp_grant(input logic [3:0] p);
    if (!p[3]) return 2'b10;
    if (!p[2]) return 2'b11;
    if (p[0] && !p[1]) return 2'b11;
    return 2'b11;
  endfunction : exp_grant
  initial begin
    #100000;
    n_fail++;
    stop_test();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    cyc(1);
    chk({allowed, scheme, oe_n}, 8'h9c);
    for (i = 0; i < 24; i++) begin
      @(posedge i_clk);
      {req, tx, lp, prio} <= (i < 4) ? corner[i] : 4'($random(seed));
      cyc(6);
      g = exp_grant({req, tx, lp, prio});
      chk({oe_n, line[1]}, {4'hc, req});
      if (g[1]) chk({7'h0, line[0]}, {7'h0, g[0]});
    end
    $display("traffic test done");
    en <= 1'b0;
    cyc(5);
    chk({allowed, oe_n}, 8'h1f);
    en <= 1'b1;
    use_scheme(3'h7, 3'h1);
    use_scheme(3'h2, 3'h2);
    for (i = 0; i < 10; i++) begin
      @(posedge i_clk);
      tx <= 1'($random(seed));
      cyc(5);
      chk({oe_n, allowed}, {4'hf, ~tx});
    end
    use_scheme(3'h3, 3'h3);
    for (i = 0; i < 10; i++) begin
      @(posedge i_clk);
      req <= 1'($random(seed));
      cyc(5);
      chk({oe_n, line[1], lan_ok}, {4'hd, req, ~req});
    end
    use_scheme(3'h4, 3'h4);
    for (i = 0; i < 10; i++) begin
      @(posedge i_clk);
      {hrm, tx} <= 2'($random(seed));
      cyc(5);
      chk({oe_n, hrm | allowed}, {hrm ? 4'hd : 4'hf, hrm | ~tx});
    end
    $display("master tests done");
    use_scheme(3'h5, 3'h5);
    for (i = 0; i < 4; i++) begin
      chk({oe_n, allowed}, {4'hf, 1'(i)});
      @(posedge i_clk);
      strobe <= 1'b1;
      @(posedge i_clk);
      strobe <= 1'b0;
      cyc(5);
    end
    sel <= 3'h1;
    load <= 1'b1;
    @(posedge i_clk);
    load <= 1'b0;
    cyc(4);
    chk({5'h0, scheme}, 8'h05);
    slot <= 1'b1;
    @(posedge i_clk);
    slot <= 1'b0;
    cyc(3);
    chk({5'h0, scheme}, 8'h01);
    $display("scheme tests done");
    stop_test();
  end
endmodule : testbench
`default_nettype wire
